// >>> logic/dli_status_map.vh
`ifndef DLI_STATUS_MAP_VH
`define DLI_STATUS_MAP_VH
// Behaviour
// - Summary error flag bit 7 sets on any of the five error conditions.
// - Error interrupt follows the summary flag directly, no local mask.
// - Writing one to the summary flag clears it; zero leaves it.
// - Ack line fault bit 6 sets when any data input is low at ack.
// - Sub-flags clear only together with the summary flag clear.
// - Cancel bit 5 sets when a request is dropped for idle while pending.
// - Timeout bit 4 sets when the target fails to ack in time.
// - Target error bit 3 sets when target error is seen at ack.
// - Parity fault bit 2 sets on received versus computed parity mismatch.
// - Status bits 1 and 0 show received parity, upper bit in bit 1.
// - Target irq flag bit 7 mirrors the target irq pin; writes ignored.
// - Busy bit 6 reads one while a link transaction is in progress.
// - Address buffer reloads with transaction attributes at each start.
// - Address buffer bit 15 holds direction, one for read.
// - Address buffer bit 14 holds size, one for 8-bit.
// - Address buffer bit 12 holds mode, one for non-blocking; others reserved.
// - Address buffer bits 7:0 hold the window-relative address.
// - Data buffer holds write data from transaction start.
// - Data buffer follows read data and holds final value at ack.
// - Address and data buffers can be read per byte or per word.
// - While summary set, buffers freeze and transactions become idle.
// - Timeout after the configured link clock cycles without ack.

// Register word offsets (byte address)
`define DLI_OFS_ERR 4'h0
`define DLI_OFS_PIN 4'h4
`define DLI_OFS_ADR 4'h8
`define DLI_OFS_DATA 4'hc
// Error status field positions
`define DLI_B_SUM 7
`define DLI_B_ACK 6
`define DLI_B_CNCL 5
`define DLI_B_TIME 4
`define DLI_B_TERR 3
`define DLI_B_PAR 2
// Pin status field positions
`define DLI_B_IRQ 7
`define DLI_B_BUSY 6
// Address buffer field positions
`define DLI_B_DIR 15
`define DLI_B_SZ8 14
`define DLI_B_XFER_NONBLOCKING 12
// Reset values
`define DLI_RST_ERR 8'h00
`define DLI_RST_W16 16'h0000
`endif

// >>> logic/dli_status.v
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`include "dli_status_map.vh"
module dli_status #(
	parameter DW = 8
) (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Avalon-MM slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// Protocol engine events, same clock
	input wire xact_start,
	input wire xact_dir,
	input wire xact_byte_size,
	input wire xact_nonblocking,
	input wire [7:0] xact_addr,
	input wire [15:0] xact_wdata,
	input wire xact_end,
	input wire rd_data_vld,
	input wire [15:0] rd_data,
	input wire ack_cycle,
	input wire [DW-1:0] ack_data,
	input wire ack_target_err,
	input wire [1:0] ack_parity,
	input wire [1:0] calc_parity,
	input wire wait_expired,
	input wire xact_cancel,
	// Target interrupt pin, asynchronous
	input wire target_irq_pin,
	// Outputs
	output wire error_irq,
	output wire suppress_xact
);
	// ==========================================================
	// Target pin synchroniser
	reg irq_s1_r, irq_s2_r, irq_s3_r, target_irq_flag_r;
	always @(posedge clk) begin
		if (srst) begin
			irq_s1_r <= 1'b0;
			irq_s2_r <= 1'b0;
			irq_s3_r <= 1'b0;
			target_irq_flag_r <= 1'b0;
		end else begin
			irq_s1_r <= target_irq_pin;
			irq_s2_r <= irq_s1_r;
			irq_s3_r <= irq_s2_r;
			if (irq_s2_r == irq_s3_r)
				target_irq_flag_r <= irq_s3_r;
		end
	end

	// ==========================================================
	// Bus decode
	wire wr_err = avs_write && (avs_address == `DLI_OFS_ERR) && avs_byteenable[0];
	wire sum_clr = wr_err && avs_writedata[`DLI_B_SUM];
	// Reads stall one cycle so the registered read data stands at the accept edge
	reg rd_done_r;
	wire rd_done_nxt = avs_read && !rd_done_r;
	always @(posedge clk) begin
		if (srst)
			rd_done_r <= 1'b0;
		else
			rd_done_r <= rd_done_nxt;
	end
	assign avs_waitrequest = avs_read && !rd_done_r;

	// ==========================================================
	// Error flags
	reg [7:0] err_r;
	reg busy_r;
	reg [15:0] adr_r, data_r;
	wire sum = err_r[`DLI_B_SUM];
	// any data line low at ack
	wire ev_ack = ack_cycle && !(&ack_data);
	wire ev_terr = ack_cycle && ack_target_err;
	wire ev_par = ack_cycle && (ack_parity != calc_parity);
	wire ev_cncl = xact_cancel || (xact_start && sum);
	// wait counter lives in the engine, expiry arrives here
	wire ev_time = wait_expired;
	wire ev_any = ev_ack | ev_terr | ev_par | ev_cncl | ev_time;
	assign error_irq = sum;
	assign suppress_xact = sum;

	always @(posedge clk) begin
		if (srst) begin
			err_r <= `DLI_RST_ERR;
		end else begin
			// sub-flags clear with summary, set wins
			if (sum_clr)
				err_r[7:2] <= 6'h00;
			// summary from any event; same cycle, sticky
			if (ev_any)
				err_r[`DLI_B_SUM] <= 1'b1;
			if (ev_ack)
				err_r[`DLI_B_ACK] <= 1'b1;
			if (ev_cncl)
				err_r[`DLI_B_CNCL] <= 1'b1;
			if (ev_time)
				err_r[`DLI_B_TIME] <= 1'b1;
			if (ev_terr)
				err_r[`DLI_B_TERR] <= 1'b1;
			if (ev_par)
				err_r[`DLI_B_PAR] <= 1'b1;
			// received parity, frozen while error pending
			if (ack_cycle && !sum)
				err_r[1:0] <= ack_parity;
		end
	end

	// ==========================================================
	// Busy and capture buffers
	always @(posedge clk) begin
		if (srst) begin
			busy_r <= 1'b0;
			adr_r <= `DLI_RST_W16;
			data_r <= `DLI_RST_W16;
		end else begin
			if (xact_start && !sum)
				busy_r <= 1'b1;
			else if (xact_end)
				busy_r <= 1'b0;
			// reload at start; frozen while error
			if (xact_start && !sum) begin
				adr_r <= 16'h0000;
				adr_r[`DLI_B_DIR] <= xact_dir;
				adr_r[`DLI_B_SZ8] <= xact_byte_size;
				adr_r[`DLI_B_XFER_NONBLOCKING] <= xact_nonblocking;
				adr_r[7:0] <= xact_addr;
				data_r <= xact_dir ? data_r : xact_wdata;
			end else if (rd_data_vld && !sum && adr_r[`DLI_B_DIR]) begin
				data_r <= rd_data;
			end
		end
	end

	// ==========================================================
	// Read mux, byte lanes honoured
	function [31:0] lane_mask;
		input [3:0] be;
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction
	reg [31:0] rd_word;
	always @* begin
		case (avs_address)
		`DLI_OFS_ERR: rd_word = {24'h000000, err_r};
		`DLI_OFS_PIN: rd_word = {24'h000000, target_irq_flag_r, busy_r, 6'h00};
		`DLI_OFS_ADR: rd_word = {16'h0000, adr_r};
		`DLI_OFS_DATA: rd_word = {16'h0000, data_r};
		default: rd_word = 32'h00000000;
		endcase
	end
	always @(posedge clk) begin
		if (srst)
			avs_readdata <= 32'h00000000;
		else if (avs_read && !rd_done_r)
			avs_readdata <= rd_word & lane_mask(avs_byteenable);
	end
endmodule

// >>> sim/dli_status_monitor.sv
`timescale 1ns/10ps
// ====
// Error flag checks
module dli_status_monitor #(parameter DW = 8) (
	input wire clk, srst, avs_read, avs_write, ack_cycle, ack_target_err, wait_expired,
	input wire xact_cancel, error_irq, avs_waitrequest,
	input wire [3:0] avs_address, avs_byteenable,
	input wire [31:0] avs_writedata, avs_readdata,
	input wire [DW-1:0] ack_data,
	input wire [1:0] ack_parity, calc_parity
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire clr = avs_write && avs_address == 4'h0 && avs_writedata[7] && avs_byteenable[0];
	wire ev = ack_cycle || wait_expired || xact_cancel;
	sequence err_rd_s;
		avs_read && avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
	endsequence
	sum_hold_a: assert property (error_irq && !clr |=> error_irq)
		else $error("flag lost");
	sum_clear_a: assert property (clr && !ev |=> !error_irq)
		else $error("flag not cleared");
	no_cause_a: assert property (!error_irq && !ev |=> !error_irq)
		else $error("flag without cause");
	ack_fault_a: assert property (ack_cycle && ack_data != {DW{1'b1}} |=> error_irq)
		else $error("ack fault missed");
	target_err_a: assert property (ack_cycle && ack_target_err |=> error_irq)
		else $error("target error missed");
	parity_err_a: assert property (ack_cycle && ack_parity != calc_parity |=> error_irq)
		else $error("parity missed");
	timeout_err_a: assert property (wait_expired |=> error_irq)
		else $error("timeout missed");
	flag_read_a: assert property (err_rd_s |=> avs_readdata[7] == $past(error_irq))
		else $error("flag read wrong");
endmodule
bind dli_status dli_status_monitor #(.DW(DW)) mon (.*);

// >>> sim/dli_target_model.sv
`timescale 1ns/10ps
// ====
// Engine and target stand-in
module dli_target_model #(parameter DW = 8) (
	input wire [2:0] op,
	input wire [15:0] d,
	input wire suppress_xact,
	output wire xact_start, xact_dir, xact_byte_size, xact_nonblocking, xact_end, rd_data_vld,
	output wire ack_cycle, ack_target_err, wait_expired, xact_cancel,
	output wire [7:0] xact_addr,
	output wire [15:0] xact_wdata, rd_data,
	output wire [DW-1:0] ack_data,
	output wire [1:0] ack_parity, calc_parity
);
	assign xact_start = op == 3'h1 || op == 3'h2;
	assign xact_cancel = xact_start && suppress_xact;
	assign xact_dir = op == 3'h2;
	assign {xact_nonblocking, xact_byte_size, xact_addr} = d[9:0];
	assign xact_wdata = d;
	assign rd_data = d;
	assign xact_end = op == 3'h3;
	assign rd_data_vld = xact_end;
	assign ack_cycle = op >= 3'h3 && op <= 3'h6;
	// One line low stands for a broken wire
	assign ack_data = op == 3'h4 ? {1'b0, {DW-1{1'b1}}} : {DW{1'b1}};
	assign ack_target_err = op == 3'h5;
	assign ack_parity = d[1:0];
	assign calc_parity = op == 3'h6 ? ~d[1:0] : d[1:0];
	assign wait_expired = op == 3'h7;
endmodule

// >>> sim/dli_status_test.sv
`timescale 1ns/10ps
// ====
// Register bank bench
module dli_status_test;
	reg clk = 0, srst = 1, avs_read = 0, avs_write = 0, target_irq_pin = 0;
	reg [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
	reg [31:0] avs_writedata = 32'h0;
	reg [2:0] op = 3'h0;
	reg [15:0] d = 16'h0, r, ea;
	reg [16:0] s = 17'h13b9b;
	reg [7:0] f;
	reg [63:0] q[$];
	integer err_total = 0, samples_checked = 0, i;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, error_irq, suppress_xact, xact_start, xact_dir, xact_byte_size;
	wire xact_nonblocking, xact_end, rd_data_vld, ack_cycle, ack_target_err, wait_expired;
	wire xact_cancel;
	wire [7:0] xact_addr, ack_data;
	wire [15:0] xact_wdata, rd_data;
	wire [1:0] ack_parity, calc_parity;
	dli_status DUT (.*);
	dli_target_model MDL (.*);
	initial forever #2 clk = ~clk;
	function [16:0] lfsr(input [16:0] x);
		lfsr = {x[15:0], x[16] ^ x[13]};
	endfunction
	always @(posedge clk) begin
		if (avs_read && !avs_waitrequest) begin
			samples_checked = samples_checked + 1;
			if ((avs_readdata & q[0][63:32]) !== q[0][31:0]) begin
				err_total = err_total + 1;
				$display("unexpected %0t readdata %h", $time, avs_readdata);
			end
			void'(q.pop_front());
		end
	end
	task rd(input [3:0] a, input [31:0] m, e);
		@(posedge clk);
		avs_read <= 1'b1;
		avs_address <= a;
		q.push_back({m, e});
		@(posedge clk);
		while (avs_waitrequest) @(posedge clk);
		avs_read <= 1'b0;
	endtask
	task wr(input [31:0] w);
		@(posedge clk);
		avs_write <= 1'b1;
		avs_address <= 4'h0;
		avs_writedata <= w;
		@(posedge clk);
		while (avs_waitrequest) @(posedge clk);
		avs_write <= 1'b0;
	endtask
	task ev(input [2:0] o);
		@(posedge clk);
		s = lfsr(s);
		r = s[15:0];
		op <= o;
		d <= r;
		@(posedge clk);
		op <= 3'h0;
	endtask
	task stop_test;
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		err_total = err_total + 1;
		stop_test;
	end
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		target_irq_pin <= 1'b1;
		rd(4'h0, 32'hff, 32'h0);
		ev(3'h1);
		rd(4'h8, 32'hd0ff, {1'b0, r[8], 1'b0, r[9], 4'h0, r[7:0]});
		rd(4'hc, 32'hffff, r);
		rd(4'h4, 32'hc0, 32'hc0);
		ev(3'h2);
		ea = {1'b1, r[8], 1'b0, r[9], 4'h0, r[7:0]};
		avs_byteenable <= 4'h2;
		rd(4'h8, 32'hd0ff, ea & 16'hd000);
		avs_byteenable <= 4'hf;
		ev(3'h3);
		rd(4'hc, 32'hffff, r);
		rd(4'h0, 32'hff, r[1:0]);
		for (i = 4; i < 8; i = i + 1) begin
			ev(i[2:0]);
			f = i == 4 ? 8'h40 : i == 5 ? 8'h08 : i == 6 ? 8'h04 : 8'h10;
			rd(4'h0, 32'hfc, 8'h80 | f);
			ev(3'h1);
			rd(4'h0, 32'hfc, 8'ha0 | f);
			rd(4'h8, 32'hd0ff, ea);
			wr(32'h7f);
			rd(4'h0, 32'hfc, 8'ha0 | f);
			wr(32'h80);
			rd(4'h0, 32'hfc, 32'h0);
		end
		stop_test;
	end
endmodule
